// ### smp_addr_step.sv
// next-address logic for wrap and continuous bursts
`timescale 1ns/1ps
module smp_addr_step #(
	parameter int AW = 22
) (
	input  wire logic [AW-1:0] addr_in,
	input  wire logic          wrap_in,
	input  wire logic [2:0]    wrap_len_in,
	output logic [AW-1:0]      next_out
);
	initial begin
		if (AW < 11) begin
			$error("address width too small for wrap lengths");
		end
	end
	wire [AW-1:0] inc = addr_in + {{(AW-1){1'b0}}, 1'b1};
	// wrap length decode; code 111 falls back to linear
	wire [AW-1:0] wmask = ~({AW{1'b1}} << ({1'b0, wrap_len_in} + 4'h4));
	wire          wrap_ok = wrap_in && (wrap_len_in != 3'h7);
	wire [AW-1:0] wrapped = (addr_in & ~wmask) | (inc & wmask);
	assign next_out = wrap_ok ? wrapped : inc;
endmodule

// ### smp_cfg.svh
// constants for the memory protection and configuration block
`ifndef SMP_CFG_SVH
`define SMP_CFG_SVH
// ==========================================
// register selectors on the register port
`define SMP_SEL_STATUS      3'h0
`define SMP_SEL_AUX_PROT    3'h1
`define SMP_SEL_CFG1        3'h2
`define SMP_SEL_CFG2        3'h3
`define SMP_SEL_CFG3        3'h4
`define SMP_SEL_CFG4        3'h5
// ==========================================
// field positions
`define SMP_SR_HWPE         7
`define SMP_SR_TOPBOT       5
`define SMP_SR_LVL_HI       4
`define SMP_SR_LVL_LO       2
`define SMP_SR_WEL          1
`define SMP_CR1_MAPLOCK     2
`define SMP_CR1_AUXLOCK     0
`define SMP_CR2_QUAD        6
`define SMP_CR2_DUAL        4
`define SMP_CR2_NV_MASK     8'hAF
`define SMP_CR3_WRAP_EN     4
// ==========================================
// reset values
`define SMP_AUX_PROT_RST    8'h00
`define SMP_REG_RST         8'h00
`define SMP_ARRAY_TOP       22'h3FFFFF
`define SMP_AUX_TOP         9'h1FF
// ==========================================
// fixed register-read latencies
`define SMP_RDREG_LAT_1     4'h8
`define SMP_RDREG_LAT_2     4'h4
`define SMP_RDREG_LAT_4     4'h2
`endif

// ### smp_host_model.sv
// host side model: frames the link with chip select and a serial clock
`timescale 1ns/1ps
module smp_host_model (
	input  wire logic frame_req_in,
	output logic      cs_n_out,
	output logic      sck_out
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
	end
	// ==========================================
	// framing
	// cs follows the request; sck idles low outside frames
	always @(frame_req_in) cs_n_out = !frame_req_in;
	always #200 sck_out = !cs_n_out && !sck_out;
endmodule

// ### smp_pkg.sv
// types for the memory protection and configuration block
package smp_pkg;
	typedef enum logic [1:0] {
		SMP_WLP_NORMAL,
		SMP_WLP_SRAM,
		SMP_WLP_B2B,
		SMP_WLP_RSVD
	} smp_wlp_t;
	typedef enum logic [1:0] {
		SMP_RD_BASIC,
		SMP_RD_ARRAY,
		SMP_RD_AUX,
		SMP_RD_REG
	} smp_rd_kind_t;
	typedef enum logic [1:0] {
		SMP_IF_SINGLE,
		SMP_IF_DUAL,
		SMP_IF_QUAD
	} smp_if_t;
endpackage

// ### smp_protect_cfg.sv
// protection, configuration and write-latch logic of the serial memory
// Behaviour
// - status write takes side and level only when pin-free and unlocked
// - level codes 1..6 protect 1/64 up to 1/2; side picks upper or lower
// - ranges end at array top or start at zero; 0 none, 7 all
// - eight 64-byte aux sections, bit n protects section n
// - aux section bits nonvolatile, default unprotected
// - aux lock protects the whole aux area regardless of section bits
// - array lock freezes protected side and level
// - config1, config2 bits 7,5,3:0 and config3 held nonvolatile
// - quad and dual mode flags read-only, default zero
// - array reads insert latency equal to read_latency_sel
// - basic read 03h always zero latency
// - register reads use 8, 4 or 2 cycles by interface mode
// - three-bit drive strength field, default 000
// - wrap enable affects reads only; writes stay continuous
// - wrap length codes 16 bytes to 1K, 111 reserved
// - wrap reads loop within aligned block until chip select rises
// - continuous access rolls from top to zero until chip select rises
// - policy 00 needs latch per write, cleared at chip select rise
// - policy 01 writes without checking the latch
// - policy 10 latch needed once, kept until write-disable
// - register writes always need the latch and clear it afterward
// - pin low with hw_protect_enable blocks register changes
// - write_enable_latch volatile, set by write-enable, zero at power-up
`timescale 1ns/1ps
`include "smp_cfg.svh"
module smp_protect_cfg #(
	parameter int AW = 22
) (
	input  wire logic          mclk_in,
	input  wire logic          reset_n_in,
	input  wire logic          cs_n_in,
	input  wire logic          write_protect_n_in,
	input  wire logic          write_enable_latch_cmd_in,
	input  wire logic          write_disable_cmd_in,
	input  wire logic          reg_wr_in,
	input  wire logic [2:0]    reg_sel_in,
	input  wire logic [7:0]    reg_wdata_in,
	input  wire logic [2:0]    reg_rsel_in,
	input  wire logic [7:0]    nv_aux_in,
	input  wire logic [7:0]    nv_sr_in,
	input  wire logic [7:0]    nv_cr1_in,
	input  wire logic [7:0]    nv_cr2_in,
	input  wire logic [7:0]    nv_cr3_in,
	input  wire logic [7:0]    nv_cr4_in,
	input  wire logic          nv_load_in,
	input  wire logic          burst_start_in,
	input  wire logic          burst_step_in,
	input  wire logic          burst_is_read_in,
	input  wire logic          burst_is_aux_in,
	input  wire logic [AW-1:0] burst_addr_in,
	input  wire logic          data_wr_in,
	input  wire smp_pkg::smp_rd_kind_t rd_kind_in,
	output logic [7:0]         reg_rdata_out,
	output logic [AW-1:0]      cur_addr_out,
	output logic               data_wr_ok_out,
	output logic               data_wr_drop_out,
	output logic [3:0]         latency_out,
	output logic [2:0]         drive_strength_out,
	output logic               wel_out,
	output logic               hw_protect_out
);
	initial begin
		if (AW != 22) begin
			$error("block protection decode needs a 22-bit array address");
		end
	end
	// ==========================================
	// pin synchronisers
	logic cs_n_s;
	logic wp_n_s;
	smp_sync #(.RST_VAL(1'b1)) u_cs_sync (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.async_in   (cs_n_in),
		.level_out  (cs_n_s)
	);
	smp_sync #(.RST_VAL(1'b1)) u_wp_sync (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.async_in   (write_protect_n_in),
		.level_out  (wp_n_s)
	);
	logic cs_prev_ff;
	wire  cs_rise = cs_n_s && !cs_prev_ff;
	// ==========================================
	// register state
	logic [7:0] sr_ff;
	logic [7:0] aux_ff;
	logic [7:0] cr1_ff;
	logic [7:0] cr2_ff;
	logic [7:0] cr3_ff;
	logic [7:0] cr4_ff;
	logic       wel_ff;
	logic       reg_wr_seen_ff;
	logic       arr_wr_seen_ff;
	logic [AW-1:0] addr_ff;
	logic       rd_ff;
	logic       aux_burst_ff;
	// ==========================================
	// protection decode
	wire        hw_prot = !wp_n_s && sr_ff[`SMP_SR_HWPE];
	wire        topbot_sel = sr_ff[`SMP_SR_TOPBOT];
	wire [2:0]  prot_lvl = sr_ff[`SMP_SR_LVL_HI:`SMP_SR_LVL_LO];
	wire        map_lock = cr1_ff[`SMP_CR1_MAPLOCK];
	wire        aux_lock = cr1_ff[`SMP_CR1_AUXLOCK];
	smp_pkg::smp_wlp_t wlp;
	assign wlp = smp_pkg::smp_wlp_t'(cr4_ff[1:0]);
	function automatic logic arr_prot(input logic [AW-1:0] a,
		input logic lower, input logic [2:0] lvl);
		logic [5:0] hi;
		logic [5:0] lim;
		hi  = a[AW-1:AW-6];
		lim = 6'h00;
		arr_prot = 1'b0;
		if (lvl == 3'h7) begin
			arr_prot = 1'b1;
		end else if (lvl != 3'h0) begin
			lim = 6'(6'h01 << (lvl - 3'h1));
			if (lower) begin
				arr_prot = hi < lim;
			end else begin
				arr_prot = hi >= 6'(7'h40 - {1'b0, lim});
			end
		end
	endfunction
	function automatic logic aux_prot(input logic [8:0] a,
		input logic [7:0] map, input logic lk);
		aux_prot = lk || map[a[8:6]];
	endfunction
	// ==========================================
	// write latch gating
	wire latch_ok = (wlp == smp_pkg::SMP_WLP_SRAM) ? 1'b1 :
		(wlp == smp_pkg::SMP_WLP_RSVD) ? 1'b0 : wel_ff;
	wire b2b_pass = (wlp == smp_pkg::SMP_WLP_B2B) && arr_wr_seen_ff;
	wire data_latch_ok = latch_ok || b2b_pass;
	wire cur_prot = aux_burst_ff ? aux_prot(addr_ff[8:0], aux_ff, aux_lock)
		: arr_prot(addr_ff, topbot_sel, prot_lvl);
	wire in_write = data_wr_in && !rd_ff && !cs_n_s;
	assign data_wr_ok_out = in_write && data_latch_ok && !cur_prot;
	assign data_wr_drop_out = in_write && !(data_latch_ok && !cur_prot);
	// ==========================================
	// register write gating
	// latch required
	wire reg_ok = reg_wr_in && wel_ff && !hw_prot;
	wire tbbp_ok = reg_ok && !map_lock;
	wire [7:0] sr_w = reg_wdata_in;
	wire [7:0] nxt_sr = {sr_w[7:6],
		tbbp_ok ? sr_w[5:2] : sr_ff[5:2], 2'b00};
	wire [7:0] nxt_cr2 = (reg_wdata_in & `SMP_CR2_NV_MASK)
		| (cr2_ff & ~`SMP_CR2_NV_MASK);
	// ==========================================
	// burst address
	logic [AW-1:0] step_addr;
	smp_addr_step #(.AW(AW)) u_step (
		.addr_in     (addr_ff),
		.wrap_in     (rd_ff && cr3_ff[`SMP_CR3_WRAP_EN]),
		.wrap_len_in (cr3_ff[2:0]),
		.next_out    (step_addr)
	);
	wire [AW-1:0] aux_step = {{(AW-9){1'b0}}, 9'(addr_ff[8:0] + 9'h001)};
	// ==========================================
	// latency select
	// fixed register latency
	wire [3:0] reg_lat = cr2_ff[`SMP_CR2_QUAD] ? `SMP_RDREG_LAT_4 :
		cr2_ff[`SMP_CR2_DUAL] ? `SMP_RDREG_LAT_2 : `SMP_RDREG_LAT_1;
	assign latency_out = (rd_kind_in == smp_pkg::SMP_RD_BASIC) ? 4'h0 :
		(rd_kind_in == smp_pkg::SMP_RD_REG) ? reg_lat : cr2_ff[3:0];
	// ==========================================
	// state
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cs_prev_ff <= 1'b1;
			aux_ff <= `SMP_AUX_PROT_RST;
			sr_ff  <= `SMP_REG_RST;
			cr1_ff <= `SMP_REG_RST;
			cr2_ff <= `SMP_REG_RST;
			cr3_ff <= `SMP_REG_RST;
			cr4_ff <= `SMP_REG_RST;
		end else begin
			cs_prev_ff <= cs_n_s;
			if (nv_load_in) begin
				aux_ff <= nv_aux_in;
				sr_ff  <= {nv_sr_in[7:2], 2'b00};
				cr1_ff <= nv_cr1_in;
				cr2_ff <= nv_cr2_in & `SMP_CR2_NV_MASK;
				cr3_ff <= nv_cr3_in;
				cr4_ff <= nv_cr4_in;
			end else if (reg_ok) begin
				if (reg_sel_in == `SMP_SEL_STATUS) begin
					sr_ff <= nxt_sr;
				end else if (reg_sel_in == `SMP_SEL_AUX_PROT) begin
					aux_ff <= reg_wdata_in;
				end else if (reg_sel_in == `SMP_SEL_CFG1) begin
					cr1_ff <= reg_wdata_in;
				end else if (reg_sel_in == `SMP_SEL_CFG2) begin
					cr2_ff <= nxt_cr2;
				end else if (reg_sel_in == `SMP_SEL_CFG3) begin
					cr3_ff <= reg_wdata_in;
				end else if (reg_sel_in == `SMP_SEL_CFG4) begin
					cr4_ff <= reg_wdata_in;
				end
			end
		end
	end
	// latch and frame tracking; set wins over a same-cycle clear
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wel_ff         <= 1'b0;
			reg_wr_seen_ff <= 1'b0;
			arr_wr_seen_ff <= 1'b0;
		end else begin
			if (write_enable_latch_cmd_in) begin
				wel_ff <= 1'b1;
			end else if (write_disable_cmd_in) begin
				wel_ff <= 1'b0;
			end else if (cs_rise && (reg_wr_seen_ff ||
				(arr_wr_seen_ff && wlp == smp_pkg::SMP_WLP_NORMAL))) begin
				wel_ff <= 1'b0;
			end
			// refused register writes still end the latch
			if (reg_wr_in) begin
				reg_wr_seen_ff <= 1'b1;
			end else if (cs_rise) begin
				reg_wr_seen_ff <= 1'b0;
			end
			if (data_wr_ok_out) begin
				arr_wr_seen_ff <= 1'b1;
			end else if (write_disable_cmd_in) begin
				arr_wr_seen_ff <= 1'b0;
			end else if (cs_rise && wlp != smp_pkg::SMP_WLP_B2B) begin
				arr_wr_seen_ff <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_ff      <= '0;
			rd_ff        <= 1'b0;
			aux_burst_ff <= 1'b0;
		end else if (burst_start_in) begin
			addr_ff      <= burst_addr_in;
			rd_ff        <= burst_is_read_in;
			aux_burst_ff <= burst_is_aux_in;
		end else if (burst_step_in && !cs_n_s) begin
			addr_ff <= aux_burst_ff ? aux_step : step_addr;
		end
	end
	// ==========================================
	// readback
	wire [7:0] sr_view = {sr_ff[7:2], wel_ff, 1'b0};
	wire [7:0] rd_mux = (reg_rsel_in == `SMP_SEL_STATUS) ? sr_view :
		(reg_rsel_in == `SMP_SEL_AUX_PROT) ? aux_ff :
		(reg_rsel_in == `SMP_SEL_CFG1) ? cr1_ff :
		(reg_rsel_in == `SMP_SEL_CFG2) ? cr2_ff :
		(reg_rsel_in == `SMP_SEL_CFG3) ? cr3_ff :
		(reg_rsel_in == `SMP_SEL_CFG4) ? cr4_ff : 8'h00;
	logic [7:0] rdata_ff;
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= rd_mux;
		end
	end
	assign reg_rdata_out      = rdata_ff;
	assign cur_addr_out       = addr_ff;
	assign drive_strength_out = cr3_ff[7:5];
	assign wel_out            = wel_ff;
	assign hw_protect_out     = hw_prot;
endmodule

// ### smp_protect_cfg_chk.sv
// assertions on the ports of the protection and configuration block
`timescale 1ns/1ps
module smp_protect_cfg_chk (
	input wire logic                  mclk_in,
	input wire logic                  reset_n_in,
	input wire logic                  write_enable_latch_cmd_in,
	input wire logic                  write_disable_cmd_in,
	input wire logic                  reg_wr_in,
	input wire logic [2:0]            reg_rsel_in,
	input wire logic                  data_wr_in,
	input wire smp_pkg::smp_rd_kind_t rd_kind_in,
	input wire logic [7:0]            reg_rdata_out,
	input wire logic                  data_wr_ok_out,
	input wire logic                  data_wr_drop_out,
	input wire logic [3:0]            latency_out,
	input wire logic                  wel_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	// ==========================================
	// latch
	sequence s_set;
		write_enable_latch_cmd_in;
	endsequence
	sequence s_clr;
		write_disable_cmd_in && !write_enable_latch_cmd_in;
	endsequence
	a_wel_set_wins: assert property (s_set |=> wel_out)
		else $error("latch not set by write enable");
	a_wel_disable: assert property (s_clr |=> !wel_out)
		else $error("latch not cleared by write disable");
	// ==========================================
	// data writes
	a_ok_qual: assert property (data_wr_ok_out |-> data_wr_in
		&& !data_wr_drop_out) else $error("write ok without cause");
	a_drop_qual: assert property (data_wr_drop_out |-> data_wr_in)
		else $error("write drop without a write");
	// ==========================================
	// latency
	a_basic_lat: assert property (rd_kind_in == smp_pkg::SMP_RD_BASIC
		|-> latency_out == 4'h0) else $error("basic read latency");
	a_reg_lat: assert property (rd_kind_in == smp_pkg::SMP_RD_REG
		|-> latency_out == 4'h8) else $error("register read latency");
	a_array_lat: assert property (rd_kind_in == smp_pkg::SMP_RD_ARRAY
		&& $past(reg_rsel_in) == 3'h3 && !$past(reg_wr_in)
		|-> latency_out == reg_rdata_out[3:0]) else $error("array latency");
	a_flags_zero: assert property ($past(reg_rsel_in) == 3'h3
		|-> !reg_rdata_out[6] && !reg_rdata_out[4])
		else $error("mode flags not zero");
endmodule
bind smp_protect_cfg smp_protect_cfg_chk smp_protect_cfg_chk_inst (.mclk_in,
	.reset_n_in, .write_enable_latch_cmd_in, .write_disable_cmd_in, .reg_wr_in,
	.reg_rsel_in, .data_wr_in, .rd_kind_in, .reg_rdata_out, .data_wr_ok_out,
	.data_wr_drop_out, .latency_out, .wel_out);

// ### smp_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module smp_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic mclk_in,
	input  wire logic reset_n_in,
	input  wire logic async_in,
	output logic      level_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;
	wire  agree = (s2_ff == s3_ff);
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			lvl_ff <= RST_VAL;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (agree) begin
				lvl_ff <= s3_ff;
			end
		end
	end
	assign level_out = lvl_ff;
endmodule

// ### tb_smp_protect_cfg.sv
// self-checking bench for the protection and configuration block
`timescale 1ns/1ps
module tb_smp_protect_cfg;
	logic                  mclk_in, reset_n_in, cs_n_in, write_protect_n_in;
	logic                  write_enable_latch_cmd_in, write_disable_cmd_in, reg_wr_in;
	logic [2:0]            reg_sel_in, reg_rsel_in, drive_strength_out;
	logic [7:0]            reg_wdata_in, nv_img, reg_rdata_out;
	logic                  nv_load_in, burst_start_in, burst_step_in;
	logic                  burst_is_read_in, burst_is_aux_in, data_wr_in;
	logic [21:0]           burst_addr_in, cur_addr_out, b;
	smp_pkg::smp_rd_kind_t rd_kind_in;
	logic [3:0]            latency_out;
	logic                  data_wr_ok_out, data_wr_drop_out, wel_out;
	logic                  hw_protect_out, frame, sck;
	int                    err_total, samples_checked;
	smp_host_model smp_host_model_inst (.frame_req_in(frame),
		.cs_n_out(cs_n_in), .sck_out(sck));
	smp_protect_cfg #(.AW(22)) smp_protect_cfg_inst (.mclk_in, .reset_n_in,
		.cs_n_in, .write_protect_n_in, .write_enable_latch_cmd_in, .write_disable_cmd_in,
		.reg_wr_in, .reg_sel_in, .reg_wdata_in, .reg_rsel_in,
		.nv_aux_in(nv_img), .nv_sr_in(nv_img), .nv_cr1_in(nv_img),
		.nv_cr2_in(nv_img), .nv_cr3_in(nv_img), .nv_cr4_in(nv_img),
		.nv_load_in, .burst_start_in, .burst_step_in, .burst_is_read_in,
		.burst_is_aux_in, .burst_addr_in, .data_wr_in, .rd_kind_in,
		.reg_rdata_out, .cur_addr_out, .data_wr_ok_out, .data_wr_drop_out,
		.latency_out, .drive_strength_out, .wel_out, .hw_protect_out);
	initial mclk_in = 1'b0;
	always #25 mclk_in = !mclk_in;
	// ==========================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic chk(input logic [21:0] got, input logic [21:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	// pin changes need a few edges to pass the synchroniser
	task automatic fr(input logic v);
		frame = v;
		cyc(6);
	endtask
	task automatic wreg(input logic [2:0] sel, input logic [7:0] d);
		fr(1);
		pulse(write_enable_latch_cmd_in);
		reg_sel_in = sel;
		reg_wdata_in = d;
		pulse(reg_wr_in);
		fr(0);
	endtask
	task automatic rreg(input logic [2:0] sel, input logic [7:0] exp);
		reg_rsel_in = sel;
		cyc(1);
		chk(22'(reg_rdata_out), 22'(exp));
	endtask
	task automatic wr(input logic [21:0] a, input logic aux, input logic ok);
		burst_addr_in = a;
		burst_is_aux_in = aux;
		burst_is_read_in = 1'b0;
		pulse(burst_start_in);
		data_wr_in = 1'b1;
		#1;
		chk(22'({data_wr_ok_out, data_wr_drop_out}), 22'({ok, !ok}));
		cyc(1);
		data_wr_in = 1'b0;
	endtask
	function automatic logic prot(logic [21:0] a, logic t, logic [2:0] p);
		logic [22:0] s;
		s = 23'h10000 << (p - 3'h1);
		if (p == 3'h0) return 1'b0;
		if (p == 3'h7) return 1'b1;
		return t ? ({1'b0, a} < s) : ({1'b0, a} >= 23'h400000 - s);
	endfunction
	// ==========================================
	// scenarios
	task automatic t_reset;
		rreg(3'h1, 8'h00);
		chk(22'(drive_strength_out), 22'h0);
		rreg(3'h3, 8'h00);
		chk(22'(wel_out), 22'h0);
		rreg(3'h6, 8'h00);
	endtask
	task automatic t_nv;
		nv_img = 8'h5A;
		pulse(nv_load_in);
		rreg(3'h3, 8'h0A);
		rreg(3'h1, 8'h5A);
		chk(22'(drive_strength_out), 22'h2);
		nv_img = 8'h00;
		pulse(nv_load_in);
	endtask
	task automatic t_regwr;
		fr(1);
		reg_wdata_in = 8'h04;
		pulse(reg_wr_in);
		fr(0);
		rreg(3'h0, 8'h00);
		wreg(3'h0, 8'h04);
		rreg(3'h0, 8'h04);
		chk(22'(wel_out), 22'h0);
		wreg(3'h0, 8'h80);
		write_protect_n_in = 1'b0;
		cyc(6);
		chk(22'(hw_protect_out), 22'h1);
		wreg(3'h0, 8'h00);
		rreg(3'h0, 8'h80);
		write_protect_n_in = 1'b1;
		cyc(6);
		wreg(3'h0, 8'h00);
		wreg(3'h2, 8'h04);
		wreg(3'h0, 8'h18);
		rreg(3'h0, 8'h00);
		wreg(3'h2, 8'h00);
		wreg(3'h0, 8'h18);
		rreg(3'h0, 8'h18);
	endtask
	task automatic t_block;
		wreg(3'h5, 8'h01);
		for (int i = 0; i < 16; i++) begin
			logic t;
			logic [2:0] p;
			logic [22:0] s;
			t = i[3];
			p = i[2:0];
			s = 23'h10000 << (p - 3'h1);
			b = t ? s[21:0] : 22'h0 - s[21:0];
			wreg(3'h0, {2'b0, t, p, 2'b0});
			fr(1);
			wr(b - 22'h1, 1'b0, !prot(b - 22'h1, t, p));
			wr(b, 1'b0, !prot(b, t, p));
			fr(0);
		end
		wreg(3'h0, 8'h00);
		wreg(3'h1, 8'hA5);
		fr(1);
		for (int n = 0; n < 8; n++) begin
			wr(22'(n * 64), 1'b1, 1'(8'h5A >> n));
			wr(22'(n * 64 + 63), 1'b1, 1'(8'h5A >> n));
		end
		fr(0);
		wreg(3'h2, 8'h01);
		fr(1);
		wr(22'h40, 1'b1, 1'b0);
		fr(0);
		wreg(3'h2, 8'h00);
	endtask
	task automatic t_lat;
		wreg(3'h3, 8'h0F);
		rd_kind_in = smp_pkg::SMP_RD_ARRAY;
		#1 chk(22'(latency_out), 22'hF);
		wreg(3'h3, 8'h06);
		chk(22'(latency_out), 22'h6);
		rreg(3'h3, 8'h06);
		rreg(3'h3, 8'h06);
		rd_kind_in = smp_pkg::SMP_RD_AUX;
		#1 chk(22'(latency_out), 22'h6);
		rd_kind_in = smp_pkg::SMP_RD_REG;
		#1 chk(22'(latency_out), 22'h8);
		rd_kind_in = smp_pkg::SMP_RD_BASIC;
		#1 chk(22'(latency_out), 22'h0);
	endtask
	task automatic t_policy;
		wreg(3'h5, 8'h00);
		fr(1);
		wr(22'h100, 1'b0, 1'b0);
		pulse(write_enable_latch_cmd_in);
		wr(22'h100, 1'b0, 1'b1);
		fr(0);
		chk(22'(wel_out), 22'h0);
		wreg(3'h5, 8'h02);
		fr(1);
		wr(22'h100, 1'b0, 1'b0);
		pulse(write_enable_latch_cmd_in);
		wr(22'h100, 1'b0, 1'b1);
		fr(0);
		chk(22'(wel_out), 22'h1);
		fr(1);
		wr(22'h101, 1'b0, 1'b1);
		pulse(write_disable_cmd_in);
		wr(22'h102, 1'b0, 1'b0);
		fr(0);
		wreg(3'h5, 8'h01);
		fr(1);
		wr(22'h100, 1'b0, 1'b1);
		fr(0);
	endtask
	task automatic t_wrap;
		for (int c = 0; c < 8; c++) begin
			logic [21:0] len;
			len = 22'h10 << c;
			wreg(3'h4, {3'b0, 1'b1, 1'b0, 3'(c)});
			fr(1);
			burst_addr_in = 22'h100000 + len - 22'h1;
			burst_is_read_in = 1'b1;
			pulse(burst_start_in);
			pulse(burst_step_in);
			chk(cur_addr_out, c < 7 ? 22'h100000 : 22'h100000 + len);
			burst_is_read_in = 1'b0;
			pulse(burst_start_in);
			pulse(burst_step_in);
			chk(cur_addr_out, 22'h100000 + len);
			fr(0);
		end
		wreg(3'h4, 8'h00);
		fr(1);
		burst_addr_in = 22'h3FFFFF;
		burst_is_read_in = 1'b1;
		pulse(burst_start_in);
		pulse(burst_step_in);
		chk(cur_addr_out, 22'h0);
		fr(0);
	endtask
	// ==========================================
	// verdict
	task automatic results;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		err_total++;
		results();
	end
	initial begin
		{reset_n_in, frame, write_enable_latch_cmd_in, write_disable_cmd_in} = '0;
		{reg_wr_in, nv_load_in, burst_start_in, burst_step_in} = '0;
		{burst_is_read_in, burst_is_aux_in, data_wr_in} = '0;
		{reg_sel_in, reg_rsel_in, reg_wdata_in, nv_img, burst_addr_in} = '0;
		rd_kind_in = smp_pkg::SMP_RD_BASIC;
		write_protect_n_in = 1'b1;
		err_total = 0;
		samples_checked = 0;
		cyc(12);
		reset_n_in = 1'b1;
		cyc(1);
		t_reset();
		t_nv();
		t_regwr();
		t_block();
		t_lat();
		t_policy();
		t_wrap();
		results();
	end
endmodule
